// ==== occ_ctrl.sv ====
// The register offsets and the Avalon-MM slave port were left to the implementer.
module occ_ctrl
  import occ_pkg::*;
(
  // Clock and resets
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              por_in,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Access protection
  input  wire logic              wr_protect_in,
  input  wire logic              dbg_access_in,
  // Sleep and requests
  input  wire logic [2:0]        sleep_mode_in,
  input  wire logic [NOSC-1:0]   periph_req_in,
  // Oscillator side
  input  wire logic [NOSC-1:0]   osc_clk_in,
  output logic      [NOSC-1:0]   osc_run_out,
  output logic      [NOSC-1:0]   osc_clk_ok_out,
  output logic      [NOSC-1:0]   osc_xtal_out,
  output logic      [GAIN_W-1:0] fast_gain_out,
  output logic                   fast_auto_amp_out,
  output logic                   ulp_run_out,
  // Pin takeover
  output logic      [NOSC-1:0]   in_pin_own_out,
  output logic      [NOSC-1:0]   out_pin_own_out,
  // Debug and brown-out
  input  wire logic              cold_plug_in,
  input  wire logic              supply_bod_rst_in,
  input  wire logic              core_bod_rst_in,
  output logic                   supply_bod_rst_out,
  output logic                   core_bod_rst_out,
  // Interrupt
  output logic                   irq_out
);

  // ****************************
  // State
  // ****************************
  typedef struct packed {
    logic [NOSC-1:0]            en;
    logic [NOSC-1:0]            xtal;
    logic [NOSC-1:0]            rsb;
    logic [NOSC-1:0]            ond;
    logic                       amp;
    logic [GAIN_W-1:0]          gain;
    logic [NOSC-1:0][SU_W-1:0]  su;
    logic [NOSC-1:0]            inten;
    logic [NOSC-1:0]            flag;
    logic [NOSC-1:0]            rdy;
    logic [NOSC-1:0][CNT_W-1:0] cnt;
    logic [NOSC-1:0]            ck1;
    logic [NOSC-1:0]            ck2;
    logic [NOSC-1:0]            ck3;
    logic [1:0]                 bod1;
    logic [1:0]                 bod2;
    logic                       cold1;
    logic                       cold2;
    logic                       cold;
    logic                       ack;
    logic [31:0]                rdata;
  } occ_st_s;

  localparam occ_st_s ST_RST = '{
    ond:     {NOSC{RST_OND}},
    default: '0
  };

  occ_st_s q;
  occ_st_s d;

  logic [NOSC-1:0] run;
  logic            req;
  logic            wr_go;
  logic            wr_ok;

  // ****************************
  // Sleep policy
  // ****************************
  // Nothing here looks at a processor halt
  // so debug halt never freezes it
  always_comb begin
    for (int i = 0; i < NOSC; i++) begin
      case (sleep_mode_in)
        OCC_ACTIVE:  run[i] = q.en[i];
        OCC_IDLE:    run[i] = q.en[i] &
                              (~q.ond[i] | periph_req_in[i]);
        OCC_STANDBY: run[i] = q.en[i] & q.rsb[i] &
                              (~q.ond[i] | periph_req_in[i]);
        default:     run[i] = q.en[i];
      endcase
    end
  end

  // ****************************
  // Bus helpers
  // ****************************
  assign req   = avs_read_in | avs_write_in;
  assign wr_go = avs_write_in & q.ack;
  // Flag register ignores protection
  // Debugger bypasses protection
  assign wr_ok = ~wr_protect_in | dbg_access_in;

  function automatic logic [31:0] ctrl_rd(
    input occ_st_s s,
    input int      i
  );
    logic [31:0] v;
    v = '0;
    v[POS_EN]   = s.en[i];
    v[POS_XTAL] = s.xtal[i];
    v[POS_RSB]  = s.rsb[i];
    v[POS_OND]  = s.ond[i];
    v[POS_SU +: SU_W] = s.su[i];
    if (i == IX_FAST) begin
      v[POS_AMP] = s.amp;
      v[POS_GAIN +: GAIN_W] = s.gain;
    end
    return v;
  endfunction : ctrl_rd

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  // ****************************
  // Next state
  // ****************************
  always_comb begin
    logic [31:0]     rv;
    logic [31:0]     wv;
    logic [NOSC-1:0] rise;
    logic [NOSC-1:0] clr;
    occ_st_s         keep;
    rv   = '0;
    wv   = '0;
    rise = '0;
    clr  = '0;
    keep = ST_RST;
    d    = q;

    // Single wait state on every access
    d.ack = req & ~q.ack;

    // Synchronisers
    d.ck1   = osc_clk_in;
    d.ck2   = q.ck1;
    d.ck3   = q.ck2;
    d.bod1  = {core_bod_rst_in, supply_bod_rst_in};
    d.bod2  = q.bod1;
    d.cold1 = cold_plug_in;
    d.cold2 = q.cold1;
    // Cold-plug latched until power-on
    d.cold  = q.cold | q.cold2;

    // Start-up counting on oscillator edges
    for (int i = 0; i < NOSC; i++) begin
      if (!run[i]) begin
        d.cnt[i] = '0;
        d.rdy[i] = 1'b0;
      end else begin
        if (q.ck2[i] && !q.ck3[i] && !q.rdy[i]) begin
          d.cnt[i] = q.cnt[i] + occ_cnt_t'(1);
        end
        d.rdy[i] = q.rdy[i] |
                   (q.cnt[i] >= (occ_cnt_t'(1) << q.su[i]));
      end
      rise[i] = d.rdy[i] & ~q.rdy[i];
    end

    // Register read capture
    case (avs_address_in)
      OFS_IEN_SET,
      OFS_IEN_CLR: rv = 32'(q.inten);
      OFS_IFLAG:   rv = 32'(q.flag);
      OFS_STATUS:  rv = {29'h0, 1'b1, q.rdy};
      OFS_FAST:    rv = ctrl_rd(q, IX_FAST);
      OFS_SLOW:    rv = ctrl_rd(q, IX_SLOW);
      OFS_DEBUG:   rv = 32'(q.cold);
      default:     rv = '0;
    endcase
    if (avs_read_in && !q.ack) begin
      d.rdata = rv;
    end

    // Register writes
    wv = merge(rv, avs_writedata_in, avs_byteenable_in);
    if (wr_go && avs_address_in == OFS_IFLAG) begin
      clr = wv[NOSC-1:0];
    end
    if (wr_go && wr_ok) begin
      case (avs_address_in)
        OFS_IEN_SET: d.inten = q.inten | wv[NOSC-1:0];
        OFS_IEN_CLR: d.inten = q.inten & ~wv[NOSC-1:0];
        OFS_FAST,
        OFS_SLOW: begin
          for (int i = 0; i < NOSC; i++) begin
            if (avs_address_in == (i == IX_FAST ? OFS_FAST : OFS_SLOW)) begin
              d.en[i]   = wv[POS_EN];
              d.xtal[i] = wv[POS_XTAL];
              d.rsb[i]  = wv[POS_RSB];
              d.ond[i]  = wv[POS_OND];
              d.su[i]   = wv[POS_SU +: SU_W];
            end
          end
          if (avs_address_in == OFS_FAST) begin
            d.amp  = wv[POS_AMP];
            d.gain = wv[POS_GAIN +: GAIN_W];
          end
        end
        default: ;
      endcase
    end

    // Ready flags: set wins over clear
    d.flag = (q.flag & ~clr) | rise;

    // Slow crystal survives non-power-on resets
    keep.en[IX_SLOW]   = d.en[IX_SLOW];
    keep.xtal[IX_SLOW] = d.xtal[IX_SLOW];
    keep.rsb[IX_SLOW]  = d.rsb[IX_SLOW];
    keep.ond[IX_SLOW]  = d.ond[IX_SLOW];
    keep.su[IX_SLOW]   = d.su[IX_SLOW];
    keep.cnt[IX_SLOW]  = d.cnt[IX_SLOW];
    keep.rdy[IX_SLOW]  = d.rdy[IX_SLOW];
    keep.cold          = d.cold;
    if (sys_rst_in) begin
      d = keep;
    end
    if (por_in) begin
      d = ST_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    q <= d;
  end

  // ****************************
  // Outputs
  // ****************************
  assign avs_waitrequest_out = req & ~q.ack;
  assign avs_readdata_out    = q.rdata;
  assign osc_run_out         = run;
  assign osc_clk_ok_out      = q.rdy;
  assign osc_xtal_out        = q.xtal;
  assign fast_gain_out       = q.gain;
  assign fast_auto_amp_out   = q.en[IX_FAST] & q.amp;
  assign ulp_run_out         = 1'b1;
  assign in_pin_own_out      = q.en;
  assign out_pin_own_out     = q.en & q.xtal;
  assign supply_bod_rst_out  = q.bod2[0] & ~q.cold;
  assign core_bod_rst_out    = q.bod2[1] & ~q.cold;
  assign irq_out             = |(q.flag & q.inten);

  // ****************************
  // Assertions
  // ****************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in || por_in);

  a_bus_one_wait: assert property (
    req && !q.ack |=> !avs_waitrequest_out || !req)
    else $error("bus answer not after one wait");

  a_ulp_always: assert property (ulp_run_out)
    else $error("ultra low power oscillator stopped");

  a_off_no_run: assert property (
    !q.en[IX_FAST] |-> !osc_run_out[IX_FAST])
    else $error("disabled oscillator running");

  a_idle_forced: assert property (
    sleep_mode_in == OCC_IDLE && q.en[IX_FAST] && !q.ond[IX_FAST]
    |-> osc_run_out[IX_FAST])
    else $error("idle forced run missing");

  a_stby_stop: assert property (
    sleep_mode_in == OCC_STANDBY && !q.rsb[IX_FAST]
    |-> !osc_run_out[IX_FAST])
    else $error("standby did not stop oscillator");

  a_pin_take: assert property (
    out_pin_own_out[IX_FAST] == (q.en[IX_FAST] && q.xtal[IX_FAST]))
    else $error("output pin ownership wrong");

  a_ext_pins: assert property (
    q.en[IX_SLOW] && !q.xtal[IX_SLOW]
    |-> in_pin_own_out[IX_SLOW] && !out_pin_own_out[IX_SLOW])
    else $error("external clock pins owned wrongly");

  a_rdy_drop: assert property (
    !osc_run_out[IX_FAST] |=> !q.rdy[IX_FAST] && q.cnt[IX_FAST] == '0)
    else $error("ready held after stop");

  a_rdy_hold: assert property (
    osc_run_out[IX_FAST] && q.rdy[IX_FAST] |=> q.rdy[IX_FAST])
    else $error("ready lost while running");

  a_rdy_early: assert property (
    $rose(q.rdy[IX_FAST]) |->
    $past(q.cnt[IX_FAST]) >= (occ_cnt_t'(1) << $past(q.su[IX_FAST])))
    else $error("ready before start-up time");

  a_flag_set: assert property (
    $rose(q.rdy[IX_FAST]) |-> q.flag[IX_FAST])
    else $error("ready flag not raised");

  a_flag_clear: assert property (
    wr_go && avs_address_in == OFS_IFLAG && avs_writedata_in[IX_FAST] &&
    avs_byteenable_in[0] && q.rdy[IX_FAST] |=> !q.flag[IX_FAST])
    else $error("flag clear write refused");

  a_bod_mask: assert property (
    q.cold |-> !supply_bod_rst_out && !core_bod_rst_out)
    else $error("brown-out reset not masked");

  a_cold_sticky: assert property (
    q.cold |=> q.cold)
    else $error("cold-plug latch lost");

  a_wp_block: assert property (
    wr_go && avs_address_in == OFS_FAST && wr_protect_in && !dbg_access_in
    |=> $stable(q.en[IX_FAST]))
    else $error("protected write took effect");

  a_slow_keep: assert property (
    @(posedge core_clk_in) disable iff (por_in)
    sys_rst_in |=> $stable(q.en[IX_SLOW]))
    else $error("slow crystal lost on reset");

  c_fast_ready: cover property ($rose(q.rdy[IX_FAST]));
  c_irq:        cover property ($rose(irq_out));
  c_cold:       cover property ($rose(q.cold));
  c_stby_run:   cover property (sleep_mode_in == OCC_STANDBY && osc_run_out[IX_SLOW]);
  c_stby_fast:  cover property (sleep_mode_in == OCC_STANDBY && osc_run_out[IX_FAST]);

endmodule : occ_ctrl

// ==== occ_ctrl_test.sv ====
module occ_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import occ_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdq;
  logic [31:0] q;
  logic        wq;
  logic        prot = 1'b0;
  logic        dbg = 1'b0;
  logic [2:0]  slp = 3'h1;
  logic [1:0]  req = 2'h0;
  logic [1:0]  oclk;
  logic [1:0]  run;
  logic [1:0]  ok;
  logic [1:0]  xt;
  logic [1:0]  ipo;
  logic [1:0]  opo;
  logic [2:0]  gain;
  logic        amp;
  logic        ulp;
  logic        sbo;
  logic        cbo;
  logic        irq;
  logic        cold = 1'b0;
  logic        sbi = 1'b0;
  logic        cbi = 1'b0;
  int          n_errors = 0;
  int          checks = 0;

  always #2.5 clk = ~clk;

  occ_osc_src #(.HALF(20ns)) u_fast (.run_in(run[0]), .clk_out(oclk[0]));
  occ_osc_src #(.HALF(30ns)) u_slow (.run_in(run[1]), .clk_out(oclk[1]));

  occ_ctrl DUT (
    .core_clk_in(clk), .sys_rst_in(rst), .por_in(por),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdq), .avs_waitrequest_out(wq),
    .wr_protect_in(prot), .dbg_access_in(dbg),
    .sleep_mode_in(slp), .periph_req_in(req), .osc_clk_in(oclk),
    .osc_run_out(run), .osc_clk_ok_out(ok), .osc_xtal_out(xt),
    .fast_gain_out(gain), .fast_auto_amp_out(amp), .ulp_run_out(ulp),
    .in_pin_own_out(ipo), .out_pin_own_out(opo),
    .cold_plug_in(cold), .supply_bod_rst_in(sbi), .core_bod_rst_in(cbi),
    .supply_bod_rst_out(sbo), .core_bod_rst_out(cbo), .irq_out(irq)
  );

  // ****************************
  // Shared tasks
  // ****************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd  <= d;
    rd  <= ~w;
    wr  <= w;
    @(posedge clk);
    while (wq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) chk({31'h0, wq}, 32'h0);
    repeat (2) @(posedge clk);
    #1;
  endtask : bus

  task automatic wait_ok(input int i, input logic v);
    int n;
    n = 0;
    while (ok[i] !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk(ok[i], v);
  endtask : wait_ok

  task automatic set_sleep(input logic [2:0] m, input logic [1:0] r);
    @(posedge clk);
    slp <= m;
    req <= r;
    #1;
  endtask : set_sleep

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset();
    bus(1'b0, OFS_FAST, 32'h0);
    chk(q, 32'h80);
    chk({ipo, opo, run}, 6'h0);
    chk(ulp, 1'b1);
    bus(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h4);
  endtask : t_reset

  task automatic t_fast_irq();
    bus(1'b1, OFS_IEN_SET, 32'h1);
    bus(1'b1, OFS_FAST, 32'h238E);
    chk(ok[0], 1'b0);
    chk({run[0], ipo[0], opo[0], xt[0]}, 4'hF);
    chk({amp, gain}, 4'hB);
    wait_ok(0, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h5);
    @(posedge clk);
    prot <= 1'b1;
    bus(1'b1, OFS_IFLAG, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, OFS_FAST, 32'h0);
    chk(run[0], 1'b1);
    @(posedge clk);
    dbg <= 1'b1;
    bus(1'b1, OFS_IEN_CLR, 32'h1);
    bus(1'b0, OFS_IEN_SET, 32'h0);
    chk(q, 32'h0);
  endtask : t_fast_irq

  task automatic t_sleep();
    set_sleep(OCC_IDLE, 2'h0);
    chk(run[0], 1'b0);
    wait_ok(0, 1'b0);
    set_sleep(OCC_IDLE, 2'h1);
    chk(run[0], 1'b1);
    wait_ok(0, 1'b1);
    chk(irq, 1'b0);
    set_sleep(OCC_STANDBY, 2'h1);
    chk(run[0], 1'b0);
    bus(1'b1, OFS_FAST, 32'h23CE);
    chk(run[0], 1'b1);
    set_sleep(OCC_STANDBY, 2'h0);
    chk(run[0], 1'b0);
    bus(1'b1, OFS_FAST, 32'h234E);
    chk(run[0], 1'b1);
    set_sleep(OCC_IDLE, 2'h0);
    chk(run[0], 1'b1);
    bus(1'b1, OFS_FAST, 32'h0);
    chk({run[0], ipo[0], opo[0]}, 3'h0);
    set_sleep(OCC_ACTIVE, 2'h0);
    @(posedge clk);
    prot <= 1'b0;
    dbg  <= 1'b0;
  endtask : t_sleep

  task automatic t_slow();
    bus(1'b1, OFS_SLOW, 32'h2080);
    bus(1'b1, OFS_SLOW, 32'h2082);
    chk({ipo[1], opo[1], xt[1]}, 3'h4);
    bus(1'b1, OFS_SLOW, 32'h2086);
    chk({ipo[1], opo[1], xt[1]}, 3'h7);
    wait_ok(1, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({ipo[1], ok[1]}, 2'h3);
    @(posedge clk);
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    #1;
    chk({ipo[1], opo[1], ok[1]}, 3'h0);
    bus(1'b0, OFS_SLOW, 32'h0);
    chk(q, 32'h80);
  endtask : t_slow

  task automatic t_bod();
    @(posedge clk);
    sbi <= 1'b1;
    cbi <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({sbo, cbo}, 2'h3);
    @(posedge clk);
    cold <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({sbo, cbo}, 2'h0);
    bus(1'b0, OFS_DEBUG, 32'h0);
    chk(q, 32'h1);
  endtask : t_bod

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_reset();
    t_fast_irq();
    t_sleep();
    t_slow();
    t_bod();
    give_verdict();
  end
endmodule : occ_ctrl_test

// ==== occ_osc_src.sv ====
module occ_osc_src
(
  // Run command
  input  wire logic run_in,
  // Oscillator clock
  output logic      clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  parameter realtime HALF = 20ns;

  // ****************************
  // Clock stands low while stopped
  // ****************************
  initial clk_out = 1'b0;
  always begin
    #HALF;
    clk_out = run_in ? ~clk_out : 1'b0;
  end
endmodule : occ_osc_src

// ==== occ_pkg.sv ====
package occ_pkg;

  // ****************************
  // Register offsets (bytes)
  // ****************************
  localparam logic [7:0] OFS_IEN_SET = 8'h00;
  localparam logic [7:0] OFS_IEN_CLR = 8'h04;
  localparam logic [7:0] OFS_IFLAG   = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_FAST    = 8'h10;
  localparam logic [7:0] OFS_SLOW    = 8'h14;
  localparam logic [7:0] OFS_DEBUG   = 8'h18;

  // ****************************
  // Control field positions
  // ****************************
  localparam int POS_EN   = 1;
  localparam int POS_XTAL = 2;
  localparam int POS_AMP  = 3;
  localparam int POS_RSB  = 6;
  localparam int POS_OND  = 7;
  localparam int POS_GAIN = 8;
  localparam int POS_SU   = 12;
  localparam int GAIN_W   = 3;
  localparam int SU_W     = 4;
  localparam int CNT_W    = 16;
  localparam int NOSC     = 2;

  // Oscillator index
  localparam int IX_FAST = 0;
  localparam int IX_SLOW = 1;

  // Reset values
  localparam logic RST_OND = 1'b1;

  // ****************************
  // Sleep modes
  // ****************************
  typedef enum logic [2:0] {
    OCC_ACTIVE  = 3'h1,
    OCC_IDLE    = 3'h2,
    OCC_STANDBY = 3'h4
  } occ_sleep_e;

  typedef logic [CNT_W-1:0] occ_cnt_t;

endpackage : occ_pkg
